/* File: hdl/hbi_pkg.sv */
// Constants and carrier types for the host bus interface
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1: Accesses are taken only while the active-low select line is low.
// R2: Separate-strobe style: write strobe low marks a write access.
// R3: Separate-strobe style: read strobe low marks a read access.
// R4: Direction style: direction high means read, low means write.
// R5: Direction style: rising edge of data strobe ends the access.
// R6: Multiplexed: shared lines carry address first, then data.
// R7: Demultiplexed: shared lines carry only data, address comes separately.
// R8: Data lines are driven only while returning read data.
// R9: Multiplexed: address latch is transparent while latch strobe is high.
// R10: Falling edge of latch strobe captures the bus address.
// R11: First access after reset samples latch strobe to fix addressing style.
// R12: Interrupt output goes low whenever an internal source requests service.
// R13: Interrupt output is open drain, only ever pulls low.
// R14: Reset input high holds the device in reset while high.
// R15: Data path is eight bits; demultiplexed mode has separate address.
// R16: FIFO transfers paced by interrupt or by DMA request.
// R17: Demultiplexed address arrives on four address inputs 0..3.
//////////////////////////////////////////////////////////////////////////////
package hbi_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [3:0] ADDR_RST = 4'h0;

    typedef enum logic [1:0] {
        HBI_UNSET = 2'b00,
        HBI_MUX = 2'b01,
        HBI_DEMUX = 2'b10
    } hbi_amode_t;

    // One access toward the internal register space
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } hbi_req_t;
endpackage

/* File: hdl/hbi_host_port.sv */
// Parallel host port: strobe decode, address latch, data drive, interrupt pin
`timescale 1ns/10ps
module hbi_host_port (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Host pins
    input wire logic cs_n,
    input wire logic wr_n_rw,
    input wire logic rd_n_data_strobe,
    input wire logic addr_latch,
    input wire logic [7:0] host_bus_lines_i,
    output logic [7:0] host_bus_lines_o,
    output logic host_bus_lines_oe,
    input wire logic [3:0] host_addr_lines,
    output logic int_n_o,
    output logic int_n_oe,
    // Bus style strap: high selects strobe-with-direction style
    input wire logic strobe_dir_style,
    // Internal side
    output hbi_pkg::hbi_req_t req,
    input wire logic [7:0] rdata,
    input wire logic irq_src,
    input wire logic fifo_req,
    input wire logic dma_mode,
    output logic dma_req,
    output hbi_pkg::hbi_amode_t amode
);
    //////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers; stage one is read only by stage two
    logic [16:0] s1, s2;
    // Reset to the idle pin levels so no false strobe edge follows reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin // [R14]
            s1 <= {1'b0, 1'b1, 1'b1, 1'b0, hbi_pkg::DATA_RST, 5'h00};
            s2 <= {1'b0, 1'b1, 1'b1, 1'b0, hbi_pkg::DATA_RST, 5'h00};
        end else begin
            s1 <= {~cs_n, wr_n_rw, rd_n_data_strobe, addr_latch, host_bus_lines_i, irq_src, strobe_dir_style,
                   fifo_req, dma_mode, 1'b0};
            s2 <= s1;
        end
    end
    // Separate address pins pass two flops as well, matching the strobe latency
    logic [3:0] addr_s1, addr_s2;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            addr_s1 <= hbi_pkg::ADDR_RST;
            addr_s2 <= hbi_pkg::ADDR_RST;
        end else begin
            addr_s1 <= host_addr_lines; // [R17]
            addr_s2 <= addr_s1;
        end
    end
    logic sel, wrl, rdl, ale, irq_s, style_s, fifo_s, dma_s;
    logic [7:0] bus_s;
    assign {sel, wrl, rdl, ale, bus_s, irq_s, style_s, fifo_s, dma_s} = s2[16:1];

    //////////////////////////////////////////////////////////////////////////
    // Access decode
    logic ale_d, ds_d, act_d;
    logic acc_rd, acc_wr, active, ds_rise;
    always_comb begin
        ds_rise = rdl & ~ds_d;
        if (style_s) begin
            active = sel & ~rdl; // [R1]
            acc_rd = active & wrl; // [R4]
            acc_wr = active & ~wrl; // [R4]
        end else begin
            active = sel & (~rdl | ~wrl); // [R1]
            acc_rd = sel & ~rdl; // [R3]
            acc_wr = sel & ~wrl; // [R2]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ale_d <= 1'b0;
            ds_d <= 1'b1;
            act_d <= 1'b0;
        end else begin
            ale_d <= ale;
            ds_d <= rdl;
            act_d <= active;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Addressing style fixed at the first access after reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            amode <= hbi_pkg::HBI_UNSET;
        end else if (amode == hbi_pkg::HBI_UNSET && active) begin
            amode <= ale ? hbi_pkg::HBI_MUX : hbi_pkg::HBI_DEMUX; // [R11]
        end
    end

    // Address latch; ALE selects multiplexed only if still high when the first access starts
    logic [3:0] addr_q;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            addr_q <= hbi_pkg::ADDR_RST;
        end else if (ale) begin
            addr_q <= bus_s[3:0]; // [R9] [R6]
        end else if (ale_d) begin
            addr_q <= addr_q; // [R10]
        end
    end
    logic [3:0] cur_addr;
    assign cur_addr = (amode == hbi_pkg::HBI_DEMUX || (amode == hbi_pkg::HBI_UNSET && !ale))
                      ? addr_s2 : addr_q; // [R7] [R17]

    //////////////////////////////////////////////////////////////////////////
    // Internal request: one pulse per access at its end (strobe release)
    logic end_acc;
    assign end_acc = style_s ? (act_d & ds_rise) : (act_d & ~active); // [R5]
    logic was_rd, was_wr;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            was_rd <= 1'b0;
            was_wr <= 1'b0;
            req <= '0;
        end else begin
            if (active) begin
                was_rd <= acc_rd;
                was_wr <= acc_wr;
            end
            req.wr <= end_acc & was_wr; // [R2] [R4]
            req.rd <= end_acc & was_rd; // [R3] [R4]
            req.addr <= cur_addr;
            if (active) begin
                req.wdata <= bus_s; // [R15]
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Data drive only during read; address phase never driven
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            host_bus_lines_o <= hbi_pkg::DATA_RST;
            host_bus_lines_oe <= 1'b0;
        end else begin
            host_bus_lines_o <= rdata;
            host_bus_lines_oe <= acc_rd & ~ale; // [R8]
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Interrupt pin and DMA pacing; output level fixed low, enable pulls
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            int_n_o <= 1'b0;
            int_n_oe <= 1'b0;
            dma_req <= 1'b0;
        end else begin
            int_n_o <= 1'b0; // [R13]
            int_n_oe <= irq_s | (fifo_s & ~dma_s); // [R12] [R16]
            dma_req <= fifo_s & dma_s; // [R16]
        end
    end

    //////////////////////////////////////////////////////////////////////////
    int_od_a: assert property (@(posedge clk_sys) disable iff (sys_rst) int_n_o == 1'b0) // [R13]
        else $error("interrupt pin driven high");
    int_follow_a: assert property (@(posedge clk_sys) disable iff (sys_rst) irq_s |=> int_n_oe) // [R12]
        else $error("interrupt not raised");
    drive_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst) host_bus_lines_oe |-> $past(sel)) // [R8] [R1]
        else $error("bus driven outside read");
    mode_fix_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        amode != hbi_pkg::HBI_UNSET |=> $stable(amode)) // [R11]
        else $error("addressing style changed");
    no_sel_a: assert property (@(posedge clk_sys) disable iff (sys_rst) !sel |-> !active) // [R1]
        else $error("access without select");
    ds_end_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        style_s && act_d && ds_rise && was_wr |=> req.wr) // [R5]
        else $error("strobe end not seen");
    ale_pass_a: assert property (@(posedge clk_sys) disable iff (sys_rst) ale |=> addr_q == $past(bus_s[3:0])) // [R9]
        else $error("latch not transparent");
    ale_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst) !ale && !ale_d |=> $stable(addr_q)) // [R10]
        else $error("latched address moved");

    // Access endings in the separate-strobe and direction styles
    sequence sep_wr_end_s;
        !style_s && act_d && !active && was_wr;
    endsequence
    sequence sep_rd_end_s;
        !style_s && act_d && !active && was_rd;
    endsequence
    sequence dir_rd_end_s;
        style_s && act_d && ds_rise && was_rd;
    endsequence
    sep_wr_a: assert property (@(posedge clk_sys) disable iff (sys_rst) sep_wr_end_s |=> req.wr) // [R2]
        else $error("write end not reported");
    sep_rd_a: assert property (@(posedge clk_sys) disable iff (sys_rst) sep_rd_end_s |=> req.rd) // [R3]
        else $error("read end not reported");
    dir_rd_a: assert property (@(posedge clk_sys) disable iff (sys_rst) dir_rd_end_s |=> req.rd) // [R4]
        else $error("strobe read end not reported");
    drive_on_a: assert property (@(posedge clk_sys) disable iff (sys_rst) acc_rd && !ale |=> host_bus_lines_oe) // [R8]
        else $error("read data not driven");
    drive_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst) !acc_rd |=> !host_bus_lines_oe) // [R8]
        else $error("bus driven without read");
    mode_mux_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        amode == hbi_pkg::HBI_UNSET && active && ale |=> amode == hbi_pkg::HBI_MUX) // [R11]
        else $error("multiplexed style not taken");
    dma_pace_a: assert property (@(posedge clk_sys) disable iff (sys_rst) fifo_s && dma_s |=> dma_req) // [R16]
        else $error("dma request missing");
endmodule

/* File: verif/hbi_host_model.sv */
// Host processor model that runs bus cycles on the parallel port pins
`timescale 1ns/10ps
module hbi_host_model (
    // Clock and bus style
    input wire logic clk_sys,
    input wire logic style,
    // Host pins
    output logic cs_n,
    output logic wr_n_rw,
    output logic rd_n_data_strobe,
    output logic addr_latch,
    output logic [7:0] bus_d,
    output logic bus_oe,
    output logic [3:0] addr,
    input wire logic [7:0] bus_i
);
    initial begin
        {cs_n, wr_n_rw, rd_n_data_strobe, addr_latch, bus_oe} = 5'h1c;
        bus_d = 8'h00;
        addr = 4'h0;
    end
    // Strobe held six cycles, well past the three-cycle spacing the port needs
    task automatic access(input logic rd, mux, sel, keep, input logic [3:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge clk_sys);
        addr_latch <= mux;
        addr <= mux ? ~a : a;
        bus_d <= {~d[7:4], a};
        bus_oe <= 1'b1;
        repeat (4) @(posedge clk_sys);
        addr_latch <= keep;
        @(posedge clk_sys);
        cs_n <= ~sel;
        wr_n_rw <= rd;
        rd_n_data_strobe <= ~(style | rd);
        bus_d <= d;
        bus_oe <= ~rd;
        repeat (6) @(posedge clk_sys);
        q = bus_i;
        {cs_n, wr_n_rw, rd_n_data_strobe} <= 3'h7;
        bus_oe <= 1'b0;
        // Released bus shows the inverse so stale data never passes
        bus_d <= ~bus_d;
    endtask
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the parallel host port
`timescale 1ns/10ps
module tb_top;
    logic clk_sys = 1'b0, sys_rst = 1'b1, style = 1'b0, irq_src = 1'b0, fifo_req = 1'b0, dma_mode = 1'b0;
    logic cs_n, wr_n_rw, rd_n_data_strobe, addr_latch, bus_oe, oe, int_n_o, int_n_oe, dma_req;
    logic [7:0] rdata = 8'h00, bus_d, bus_o, bus, q;
    logic [3:0] addr;
    logic [31:0] lfsr = 32'hd1bb5304;
    hbi_pkg::hbi_req_t req;
    hbi_pkg::hbi_amode_t amode;
    hbi_pkg::hbi_req_t exp_q[$];
    int failures = 0, cmp_count = 0, cycles = 0;
    always #2.5 clk_sys = ~clk_sys;
    assign bus = bus_oe ? bus_d : (oe ? bus_o : bus_d);
    hbi_host_model u_hbi_host_model (.clk_sys(clk_sys), .style(style), .cs_n(cs_n), .wr_n_rw(wr_n_rw),
        .rd_n_data_strobe(rd_n_data_strobe), .addr_latch(addr_latch), .bus_d(bus_d), .bus_oe(bus_oe),
        .addr(addr), .bus_i(bus));
    hbi_host_port u_hbi_host_port (.clk_sys(clk_sys), .sys_rst(sys_rst), .cs_n(cs_n), .wr_n_rw(wr_n_rw),
        .rd_n_data_strobe(rd_n_data_strobe), .addr_latch(addr_latch), .host_bus_lines_i(bus),
        .host_bus_lines_o(bus_o), .host_bus_lines_oe(oe), .host_addr_lines(addr), .int_n_o(int_n_o),
        .int_n_oe(int_n_oe), .strobe_dir_style(style), .req(req), .rdata(rdata), .irq_src(irq_src),
        .fifo_req(fifo_req), .dma_mode(dma_mode), .dma_req(dma_req), .amode(amode));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("Counts: failures=%0d compares=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Read data field is masked: only writes carry a defined value
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            report_and_stop();
        end
        if ((req.wr | req.rd) === 1'b1) begin
            if (exp_q.size() == 0)
                check(req, 14'h0000);
            else begin
                check({req.wr, req.rd, req.addr, req.wdata & {8{req.wr}}}, exp_q[0]);
                void'(exp_q.pop_front());
            end
        end
    end
    task automatic run(input logic rd, mux, sel, keep);
        logic [3:0] a;
        logic [7:0] d;
        lfsr = next_rand(lfsr);
        a = lfsr[3:0];
        d = keep ? {lfsr[11:8], lfsr[3:0]} : lfsr[11:4];
        rdata <= lfsr[19:12];
        if (sel)
            exp_q.push_back({~rd, rd, a, rd ? 8'h00 : d});
        u_hbi_host_model.access(rd, mux, sel, keep, a, d, q);
        if (rd && sel)
            check(q, lfsr[19:12]);
        repeat (10) @(posedge clk_sys);
        check(oe, 0);
        check(exp_q.size(), 0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        run(1'b0, 1'b0, 1'b1, 1'b0);
        check(amode, hbi_pkg::HBI_DEMUX);
        for (int i = 0; i < 6; i++)
            run(i[0], 1'b0, i != 3, 1'b0);
        sys_rst <= 1'b1;
        style <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check(amode, hbi_pkg::HBI_UNSET);
        sys_rst <= 1'b0;
        run(1'b0, 1'b1, 1'b1, 1'b1);
        check(amode, hbi_pkg::HBI_MUX);
        for (int i = 0; i < 6; i++)
            run(i[0], 1'b1, 1'b1, 1'b0);
        for (int i = 0; i < 3; i++) begin
            irq_src <= i == 0;
            fifo_req <= i != 0;
            dma_mode <= i == 2;
            repeat (5) @(posedge clk_sys);
            check({int_n_oe, int_n_o, dma_req}, {i != 2, 1'b0, i == 2});
        end
        report_and_stop();
    end
endmodule
